// file: design/sad_decoder.sv
// Register address decoder for a dual-channel serial controller on a multiplexed bus
`timescale 1ns/10ps
module sad_decoder (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Host bus
  input wire logic [7:0] muxedAddrDataBus,
  input wire logic addressStrobeN,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic dataSel,
  // Decoder state
  output logic shiftRight,
  output logic addrChanA,
  output logic [3:0] addrReg,
  // Shared and per-channel control registers
  output logic [7:0] vectorReg,
  output logic [7:0] masterIntReg,
  output logic [1:0][7:0] intStatusReg,
  output logic [1:0][7:0] extCtrlReg,
  // Write access to the channel logic
  output logic wrPulse,
  output logic wrChanA,
  output logic [4:0] wrLoc,
  output logic [7:0] wrData,
  // Read access to the channel logic
  output logic rdPulse,
  output sad_pkg::sad_rd_sel_t rdSel
);

  sad_pkg::sad_state_t stQ;
  sad_pkg::sad_state_t stD;
  logic asRise;
  logic chanIdx;
  logic fifoOn;
  logic extOn;

  function automatic sad_pkg::sad_addr_t decodeAddr(input logic [7:0] bus, input logic right);
    sad_pkg::sad_addr_t a;
    // channel bit by mode, bit zero alternates channels
    a.chanA = right ? bus[sad_pkg::RIGHT_CHAN_BIT] : bus[sad_pkg::LEFT_CHAN_BIT];
    a.regNum = bus[sad_pkg::REG_LSB +: 4];
    return a;
  endfunction

  function automatic sad_pkg::sad_rd_sel_t readMap(input logic [3:0] loc, input logic chA,
                                                  input logic fifo, input logic ext);
    sad_pkg::sad_rd_sel_t s;
    logic both;
    both = fifo & ext;
    s.chanA = chA;
    s.srcIsWrite = 1'b0;
    s.num = {1'b0, loc};
    unique case ({1'b0, loc})
      sad_pkg::LOC_MISC_LOW: begin
        s.srcIsWrite = both;
        s.num = both ? sad_pkg::LOC_MISC_LOW : sad_pkg::RR_PRIMARY;
      end
      sad_pkg::LOC_TX_PARAM: begin
        s.srcIsWrite = both;
        s.num = both ? sad_pkg::LOC_TX_PARAM : sad_pkg::RR_SPECIAL_RX;
      end
      sad_pkg::LOC_FRAME_LOW: s.num = fifo ? sad_pkg::LOC_FRAME_LOW : sad_pkg::RR_VECTOR_BACK;
      sad_pkg::LOC_FRAME_HIGH: s.num = fifo ? sad_pkg::LOC_FRAME_HIGH : sad_pkg::RR_PENDING;
      sad_pkg::LOC_MASTER_INT: begin
        s.srcIsWrite = both;
        s.num = both ? sad_pkg::LOC_RX_PARAM : sad_pkg::RR_BAUD_HIGH;
      end
      sad_pkg::LOC_IRQ_READBACK: begin
        s.srcIsWrite = both;
        s.num = both ? sad_pkg::LOC_MISC_CTRL : sad_pkg::RR_INT_CTRL_BACK;
      end
      sad_pkg::LOC_EXT_ALIAS: begin
        s.srcIsWrite = both;
        s.num = both ? sad_pkg::LOC_EXT_CTRL : sad_pkg::LOC_EXT_ALIAS;
      end
      default: s.num = {1'b0, loc};
    endcase
    return s;
  endfunction

  assign asRise = addressStrobeN & ~stQ.asPrev;
  assign chanIdx = stQ.addr.chanA;
  assign fifoOn = stQ.intStatus[chanIdx][sad_pkg::FIFO_EN_BIT];
  assign extOn = stQ.extCtrl[chanIdx][sad_pkg::EXT_READ_BIT];

  always_comb begin
    stD = stQ;
    stD.asPrev = addressStrobeN;
    stD.wrPulse = 1'b0;
    stD.rdPulse = 1'b0;
    // capture on strobe edge, hold otherwise
    if (asRise) begin
      stD.addr = decodeAddr(muxedAddrDataBus, stQ.shiftRight);
    end
    // Access uses the address from the previous strobe, so a same-cycle strobe is safe
    if (wrStrobe) begin
      stD.wrPulse = 1'b1;
      stD.wrChanA = stQ.addr.chanA;
      stD.wrData = muxedAddrDataBus;
      // seventeenth location is the transmit buffer
      stD.wrLoc = dataSel ? sad_pkg::LOC_TX_BUFFER : {1'b0, stQ.addr.regNum};
      if (!dataSel) begin
        unique case ({1'b0, stQ.addr.regNum})
          sad_pkg::LOC_CMD: begin
            // mode bit lives in channel B, set by command code only
            if (!stQ.addr.chanA && muxedAddrDataBus[1:0] == sad_pkg::CMD_SHIFT_LEFT) begin
              stD.shiftRight = 1'b0;
            end
            if (!stQ.addr.chanA && muxedAddrDataBus[1:0] == sad_pkg::CMD_SHIFT_RIGHT) begin
              stD.shiftRight = 1'b1;
            end
          end
          sad_pkg::LOC_VECTOR: stD.vector = muxedAddrDataBus;
          sad_pkg::LOC_MASTER_INT: stD.masterInt = muxedAddrDataBus;
          sad_pkg::LOC_INT_STATUS: stD.intStatus[chanIdx] = muxedAddrDataBus;
          sad_pkg::LOC_FRAME_HIGH: begin
            // redirect to extended control only when enabled
            if (stQ.intStatus[chanIdx][sad_pkg::EXT_WRITE_EN_BIT]) begin
              stD.extCtrl[chanIdx] = muxedAddrDataBus;
              stD.wrLoc = sad_pkg::LOC_EXT_CTRL;
            end
          end
          default: ;
        endcase
      end
    end else if (rdStrobe) begin
      stD.rdPulse = 1'b1;
      stD.rdSel = dataSel ? sad_pkg::sad_rd_sel_t'{srcIsWrite: 1'b0, chanA: stQ.addr.chanA, num: sad_pkg::LOC_DATA}
                          : readMap(stQ.addr.regNum, stQ.addr.chanA, fifoOn, extOn);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stQ <= '0;
      stQ.asPrev <= 1'b1;
      stQ.shiftRight <= 1'b0;
      stQ.vector <= sad_pkg::VECTOR_RST;
      stQ.masterInt <= sad_pkg::MASTER_INT_RST;
      stQ.intStatus <= {sad_pkg::INT_STATUS_RST, sad_pkg::INT_STATUS_RST};
      stQ.extCtrl <= {sad_pkg::EXT_CTRL_RST, sad_pkg::EXT_CTRL_RST};
    end else begin
      stQ <= stD;
    end
  end

  assign shiftRight = stQ.shiftRight;
  assign addrChanA = stQ.addr.chanA;
  assign addrReg = stQ.addr.regNum;
  assign vectorReg = stQ.vector;
  assign masterIntReg = stQ.masterInt;
  assign intStatusReg = stQ.intStatus;
  assign extCtrlReg = stQ.extCtrl;
  assign wrPulse = stQ.wrPulse;
  assign wrChanA = stQ.wrChanA;
  assign wrLoc = stQ.wrLoc;
  assign wrData = stQ.wrData;
  assign rdPulse = stQ.rdPulse;
  assign rdSel = stQ.rdSel;

  // Reset behaviour is checked without the reset disable
  a_reset_mode_left: assert property (@(posedge mclk) !rst_n |=> !stQ.shiftRight &&
      !stQ.intStatus[0][sad_pkg::FIFO_EN_BIT] && !stQ.intStatus[1][sad_pkg::FIFO_EN_BIT])
    else $error("reset did not select shift-left or clear fifo enable");
  a_reset_fifo_off: assert property (@(posedge mclk) disable iff (!rst_n)
      rdStrobe && !wrStrobe && !dataSel && stQ.addr.regNum == 4'h6 && !fifoOn |=>
      !rdSel.srcIsWrite && rdSel.num == sad_pkg::RR_VECTOR_BACK)
    else $error("location six mapped to frame count while fifo off");
  a_addr_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      !asRise |=> $stable(stQ.addr))
    else $error("latched address moved without strobe");
  a_left_decode: assert property (@(posedge mclk) disable iff (!rst_n)
      asRise && !stQ.shiftRight |=> addrChanA == $past(muxedAddrDataBus[5]) &&
      addrReg == $past(muxedAddrDataBus[4:1]))
    else $error("shift-left decode wrong");
  a_right_decode: assert property (@(posedge mclk) disable iff (!rst_n)
      asRise && stQ.shiftRight |=> addrChanA == $past(muxedAddrDataBus[0]) &&
      addrReg == $past(muxedAddrDataBus[4:1]))
    else $error("shift-right decode wrong");
  a_mode_by_cmd: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $changed(stQ.shiftRight) |->
      $past(wrStrobe && !dataSel && !stQ.addr.chanA && stQ.addr.regNum == 4'h0))
    else $error("decode mode changed without channel B command");
  a_ext_gated: assert property (@(posedge mclk) disable iff (!rst_n)
      wrStrobe && !dataSel && stQ.addr.regNum == 4'h7 && !stQ.intStatus[chanIdx][0] |=> $stable(stQ.extCtrl))
    else $error("extended control written while gated");
  a_shared_vector: assert property (@(posedge mclk) disable iff (!rst_n)
      wrStrobe && !dataSel && stQ.addr.regNum == 4'h2 |=> vectorReg == $past(muxedAddrDataBus) ##1
      ($stable(vectorReg) || (wrPulse && wrLoc == sad_pkg::LOC_VECTOR)))
    else $error("shared vector not written from channel");
  a_fifo_map: assert property (@(posedge mclk) disable iff (!rst_n)
      rdStrobe && !wrStrobe && !dataSel && stQ.addr.regNum == 4'h7 |=>
      rdPulse && !rdSel.srcIsWrite && rdSel.num == ($past(fifoOn) ? 5'h07 : 5'h03))
    else $error("location seven read mapping wrong");
  a_ext_map: assert property (@(posedge mclk) disable iff (!rst_n)
      rdStrobe && !wrStrobe && !dataSel && stQ.addr.regNum == 4'he && fifoOn && extOn |=>
      rdSel.srcIsWrite && rdSel.num == sad_pkg::LOC_EXT_CTRL)
    else $error("extended read of location fourteen wrong");
  a_plain_alias: assert property (@(posedge mclk) disable iff (!rst_n)
      rdStrobe && !wrStrobe && !dataSel && stQ.addr.regNum == 4'h9 && !extOn |=>
      !rdSel.srcIsWrite && rdSel.num == 5'h0d)
    else $error("location nine alias wrong");

  c_shift_right: cover property (@(posedge mclk) disable iff (!rst_n) $rose(stQ.shiftRight));
  c_ext_write: cover property (@(posedge mclk) disable iff (!rst_n) wrPulse && wrLoc == sad_pkg::LOC_EXT_CTRL);
  c_ext_read: cover property (@(posedge mclk) disable iff (!rst_n) rdPulse && rdSel.srcIsWrite);
  c_tx_buffer: cover property (@(posedge mclk) disable iff (!rst_n) wrPulse && wrLoc == sad_pkg::LOC_TX_BUFFER);

endmodule // sad_decoder

// file: pkg/sad_pkg.sv
// Constants and carrier types for the serial controller register address decoder
package sad_pkg;
  // Write locations within a channel, 0..15 are the register numbers
  localparam logic [4:0] LOC_CMD = 5'h00;
  localparam logic [4:0] LOC_VECTOR = 5'h02;
  localparam logic [4:0] LOC_RX_PARAM = 5'h03;
  localparam logic [4:0] LOC_MISC_LOW = 5'h04;
  localparam logic [4:0] LOC_TX_PARAM = 5'h05;
  localparam logic [4:0] LOC_FRAME_LOW = 5'h06;
  localparam logic [4:0] LOC_FRAME_HIGH = 5'h07;
  localparam logic [4:0] LOC_DATA = 5'h08;
  localparam logic [4:0] LOC_MASTER_INT = 5'h09;
  localparam logic [4:0] LOC_MISC_CTRL = 5'h0a;
  localparam logic [4:0] LOC_IRQ_READBACK = 5'h0b;
  localparam logic [4:0] LOC_BAUD_HIGH = 5'h0d;
  localparam logic [4:0] LOC_EXT_ALIAS = 5'h0e;
  localparam logic [4:0] LOC_INT_STATUS = 5'h0f;
  // Extra write locations beyond the sixteen numbered ones
  localparam logic [4:0] LOC_TX_BUFFER = 5'h10;
  localparam logic [4:0] LOC_EXT_CTRL = 5'h11;
  // Read register numbers used by the alias map
  localparam logic [4:0] RR_PRIMARY = 5'h00;
  localparam logic [4:0] RR_SPECIAL_RX = 5'h01;
  localparam logic [4:0] RR_VECTOR_BACK = 5'h02;
  localparam logic [4:0] RR_PENDING = 5'h03;
  localparam logic [4:0] RR_BAUD_HIGH = 5'h0d;
  localparam logic [4:0] RR_INT_CTRL_BACK = 5'h0f;
  // Bus bit positions for the two decode modes
  localparam int LEFT_CHAN_BIT = 5;
  localparam int RIGHT_CHAN_BIT = 0;
  localparam int REG_LSB = 1;
  // Field positions inside stored registers
  localparam int EXT_WRITE_EN_BIT = 0;
  localparam int FIFO_EN_BIT = 2;
  localparam int EXT_READ_BIT = 6;
  // Decode-mode command in the low bits of a channel B command write
  localparam logic [1:0] CMD_SHIFT_LEFT = 2'h2;
  localparam logic [1:0] CMD_SHIFT_RIGHT = 2'h3;
  // Reset values
  localparam logic [7:0] VECTOR_RST = 8'h00;
  localparam logic [7:0] MASTER_INT_RST = 8'h00;
  localparam logic [7:0] INT_STATUS_RST = 8'h00;
  localparam logic [7:0] EXT_CTRL_RST = 8'h00;

  typedef struct packed {
    logic srcIsWrite;
    logic chanA;
    logic [4:0] num;
  } sad_rd_sel_t;

  typedef struct packed {
    logic chanA;
    logic [3:0] regNum;
  } sad_addr_t;

  typedef struct packed {
    logic asPrev;
    logic shiftRight;
    sad_addr_t addr;
    logic [7:0] vector;
    logic [7:0] masterInt;
    logic [1:0][7:0] intStatus;
    logic [1:0][7:0] extCtrl;
    logic wrPulse;
    logic wrChanA;
    logic [4:0] wrLoc;
    logic [7:0] wrData;
    logic rdPulse;
    sad_rd_sel_t rdSel;
  } sad_state_t;
endpackage

// file: tb/sad_decoder_tb.sv
// Self-checking bench for the register address decoder
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module sad_decoder_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] bus;
  logic asN, wrS, rdS, dSel, shiftRight, addrChanA, wrPulse, wrChanA, rdPulse;
  logic [3:0] addrReg;
  logic [7:0] vectorReg, masterIntReg, wrData;
  logic [1:0][7:0] intStatusReg, extCtrlReg;
  logic [4:0] wrLoc;
  sad_pkg::sad_rd_sel_t rdSel;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  localparam logic [4:0] RLOC [8] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0b, 5'h0e, 5'h0c};
  always #50 mclk = ~mclk;
  sad_host_model u_host (.mclk(mclk), .muxedAddrDataBus(bus), .addressStrobeN(asN), .wrStrobe(wrS),
    .rdStrobe(rdS), .dataSel(dSel));
  sad_decoder u_dut (.mclk(mclk), .rst_n(rst_n), .muxedAddrDataBus(bus), .addressStrobeN(asN),
    .wrStrobe(wrS), .rdStrobe(rdS), .dataSel(dSel), .shiftRight(shiftRight), .addrChanA(addrChanA),
    .addrReg(addrReg), .vectorReg(vectorReg), .masterIntReg(masterIntReg), .intStatusReg(intStatusReg),
    .extCtrlReg(extCtrlReg), .wrPulse(wrPulse), .wrChanA(wrChanA), .wrLoc(wrLoc), .wrData(wrData),
    .rdPulse(rdPulse), .rdSel(rdSel));
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Whole run needs under two hundred cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // Unused bits set so that decoding them would show
  function automatic logic [7:0] la(logic a, logic [3:0] r);
    return {2'b11, a, r, 1'b1};
  endfunction
  function automatic logic [7:0] rt(logic a, logic [3:0] r);
    return {2'b11, ~a, r, a};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.acc(a, 1'b1, 1'b0, d);
  endtask
  function automatic sad_pkg::sad_rd_sel_t expRd(logic [4:0] l, logic f, logic e);
    logic fe;
    logic w;
    logic [4:0] n;
    fe = f & e;
    w = fe && (l inside {5'h04, 5'h05, 5'h09, 5'h0b, 5'h0e});
    case (l)
      5'h04, 5'h05: n = fe ? l : l - 5'h04;
      5'h06, 5'h07: n = f ? l : l - 5'h04;
      5'h09: n = fe ? 5'h03 : 5'h0d;
      5'h0b: n = fe ? 5'h0a : 5'h0f;
      5'h0e: n = fe ? 5'h11 : 5'h0e;
      default: n = l;
    endcase
    return {w, 1'b1, n};
  endfunction
  task automatic t_left();
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = 0; i < 4; i++) begin
        wr(la(ch[0], 4'(i * 3 + 1)), 8'ha0 + 8'(i));
        `CHK("chan", ch[0], addrChanA)
        `CHK("reg", 4'(i * 3 + 1), addrReg)
        `CHK("wrLoc", 5'(i * 3 + 1), wrLoc)
        `CHK("wrChan", ch[0], wrChanA)
        `CHK("wrData", 8'ha0 + 8'(i), wrData)
        `CHK("wrPulse", 1'b1, wrPulse)
      end
    end
    u_host.acc(la(1'b1, 4'h8), 1'b1, 1'b1, 8'h5a);
    `CHK("txbuf", 5'h10, wrLoc)
    @(posedge mclk);
    #1 `CHK("pulse end", 1'b0, wrPulse)
    `CHK("reg held", 4'h8, addrReg)
  endtask
  task automatic t_shared();
    wr(la(1'b1, 4'h2), 8'h11);
    `CHK("vector A", 8'h11, vectorReg)
    wr(la(1'b0, 4'h9), 8'h22);
    `CHK("master B", 8'h22, masterIntReg)
    wr(la(1'b0, 4'h2), 8'h33);
    `CHK("vector B", 8'h33, vectorReg)
    wr(la(1'b1, 4'h9), 8'h66);
    `CHK("master A", 8'h66, masterIntReg)
  endtask
  task automatic t_mode();
    wr(la(1'b1, 4'h0), 8'h03);
    @(posedge mclk);
    #1 `CHK("mode chA", 1'b0, shiftRight)
    wr(la(1'b0, 4'h0), 8'h00);
    @(posedge mclk);
    #1 `CHK("mode null", 1'b0, shiftRight)
    wr(la(1'b0, 4'h0), 8'h03);
    @(posedge mclk);
    #1 `CHK("mode right", 1'b1, shiftRight)
    // Identical settings by stepping the address; bit five set must not pick channel A
    for (int a = 0; a < 2; a++) begin
      wr(8'h28 + 8'(a), 8'h44);
      `CHK("r chan", a[0], addrChanA)
      `CHK("r reg", 4'h4, addrReg)
      `CHK("r wrChan", a[0], wrChanA)
      `CHK("r wrData", 8'h44, wrData)
    end
    wr(rt(1'b0, 4'h0), 8'h02);
    @(posedge mclk);
    #1 `CHK("mode left", 1'b0, shiftRight)
  endtask
  task automatic t_ext();
    wr(la(1'b1, 4'h7), 8'h40);
    `CHK("ext locked", 5'h07, wrLoc)
    `CHK("ext kept", 8'h00, extCtrlReg[1])
    wr(la(1'b1, 4'hf), 8'h01);
    `CHK("intStat", 8'h01, intStatusReg[1])
    wr(la(1'b1, 4'h7), 8'h40);
    `CHK("ext loc", 5'h11, wrLoc)
    `CHK("ext A", 16'h4000, extCtrlReg)
  endtask
  task automatic rdMap(input logic f, input logic e);
    for (int i = 0; i < 8; i++) begin
      u_host.acc(la(1'b1, RLOC[i][3:0]), 1'b0, 1'b0, 8'h00);
      `CHK("rdPulse", 1'b1, rdPulse)
      `CHK("rdSel", expRd(RLOC[i], f, e), rdSel)
    end
    // Data location ignores the latched register number
    u_host.acc(la(1'b0, 4'h3), 1'b0, 1'b1, 8'h00);
    `CHK("rd data", 7'h08, rdSel)
    @(posedge mclk);
    #1 `CHK("rdPulse end", 1'b0, rdPulse)
  endtask
  // Reset in mid-run while shift-right and the fifo mapping are both on
  task automatic t_reset_mid();
    wr(la(1'b0, 4'h0), 8'h03);
    `CHK("pre mode", 1'b1, shiftRight)
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    `CHK("mid mode", 1'b0, shiftRight)
    `CHK("mid fifo", 16'h0000, intStatusReg)
    u_host.acc(la(1'b1, 4'h6), 1'b0, 1'b0, 8'h00);
    `CHK("mid map", expRd(5'h06, 1'b0, 1'b0), rdSel)
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    `CHK("reset mode", 1'b0, shiftRight)
    `CHK("reset fifo", 16'h0000, intStatusReg)
    `CHK("reset regs", 32'h0, {vectorReg, masterIntReg, extCtrlReg})
    t_left();
    t_shared();
    t_mode();
    t_ext();
    rdMap(1'b0, 1'b1);
    wr(la(1'b1, 4'hf), 8'h05);
    rdMap(1'b1, 1'b1);
    wr(la(1'b1, 4'h7), 8'h00);
    rdMap(1'b1, 1'b0);
    t_reset_mid();
    report_and_stop();
  end
endmodule // sad_decoder_tb

// file: tb/sad_host_model.sv
// Host processor model for the multiplexed address/data bus
`timescale 1ns/10ps
module sad_host_model (
  // Clock
  input wire logic mclk,
  // Host bus
  output logic [7:0] muxedAddrDataBus,
  output logic addressStrobeN,
  output logic wrStrobe,
  output logic rdStrobe,
  output logic dataSel
);
  initial begin
    muxedAddrDataBus = 8'h00;
    addressStrobeN = 1'b1;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    dataSel = 1'b0;
  end
  // Entered just after a rising edge; returns just after the edge that takes the access
  task automatic acc(input logic [7:0] a, input logic wr, input logic ds, input logic [7:0] d);
    muxedAddrDataBus = a;
    addressStrobeN = 1'b0;
    @(posedge mclk);
    #1 addressStrobeN = 1'b1;
    @(posedge mclk);
    // Released bus on a read shows the inverse, so a stale address cannot look valid
    #1 muxedAddrDataBus = wr ? d : ~a;
    wrStrobe = wr;
    rdStrobe = ~wr;
    dataSel = ds;
    @(posedge mclk);
    #1 wrStrobe = 1'b0;
    rdStrobe = 1'b0;
  endtask
endmodule // sad_host_model
